// ==== verilog/crsd_consts.svh ====
`ifndef CRSD_CONSTS_SVH
`define CRSD_CONSTS_SVH

// register byte addresses
`define CRSD_ADDR_STATUS 12'h000
`define CRSD_ADDR_CTRL 12'h004
`define CRSD_ADDR_PERIOD 12'h008
`define CRSD_ADDR_REFHZ 12'h00c
`define CRSD_ADDR_PLATHZ 12'h010
`define CRSD_ADDR_COREHZ 12'h014
`define CRSD_ADDR_MEMHZ 12'h018

// ctrl field positions and reset value
`define CRSD_CTRL_OUT_EN_BIT 0
`define CRSD_CTRL_OUT_VAL_BIT 1
`define CRSD_CTRL_RESET 32'h0000_0000

// status field positions
`define CRSD_ST_PRATIO_LSB 0
`define CRSD_ST_MULT_LSB 4
`define CRSD_ST_CRATIO_LSB 12
`define CRSD_ST_VALID_BIT 14
`define CRSD_ST_BUS64_BIT 15
`define CRSD_ST_LOCKED_BIT 16
`define CRSD_ST_SLOW_BIT 17

// default reference clock (hz) and platform minimum (hz)
`define CRSD_REF_HZ_RESET 32'h03f9_40aa
`define CRSD_PLAT_MIN_HZ 32'h0beb_c200

// platform-ratio strap codes
`define CRSD_PR_16 4'h0
`define CRSD_PR_2 4'h2
`define CRSD_PR_3 4'h3
`define CRSD_PR_4 4'h4
`define CRSD_PR_5 4'h5
`define CRSD_PR_6 4'h6
`define CRSD_PR_8 4'h8
`define CRSD_PR_9 4'h9
`define CRSD_PR_10 4'ha
`define CRSD_PR_12 4'hc

// core ratio in halves: 2, 2.5, 3, 3.5
`define CRSD_CR_HALF_00 4'h4
`define CRSD_CR_HALF_01 4'h5
`define CRSD_CR_HALF_10 4'h6
`define CRSD_CR_HALF_11 4'h7

// platform divide for the memory bus clock
`define CRSD_MEM_DIV 8'h02

`endif

// ==== verilog/crsd_pkg.sv ====
`default_nettype none
package crsd_pkg;
    typedef struct packed {
        logic [3:0] platform_ratio_strap;
        logic core_ratio_strap_upper;
        logic core_ratio_strap_lower;
        logic bus_width_strap;
    } crsd_straps_t;

    typedef struct packed {
        logic [7:0] plat_mult;
        logic [3:0] core_half;
        logic ratio_valid;
        logic bus_64;
    } crsd_ratio_t;

    typedef enum logic [1:0] {
        CRSD_HELD,
        CRSD_CAPTURE,
        CRSD_RUN
    } crsd_state_t;
endpackage
`default_nettype wire

// ==== verilog/crsd_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module crsd_sync #(
    parameter int WIDTH = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/crsd_clock_ratio_strap_decoder.sv ====
// Notes on behaviour
// - the four-bit platform-ratio strap is sampled at power-up and its value picks the platform multiplier.
// - code 0000 gives a platform clock sixteen times the reference clock.
// - codes 0010 to 0110 give multipliers 2 to 6.
// - codes 1000, 1001, 1010 and 1100 give multipliers 8, 9, 10 and 12.
// - the core-ratio strap is the upper strap over the lower strap, sampled at power-up.
// - core codes 00, 01, 10, 11 give core clock 2, 2.5, 3 and 3.5 times the platform clock.
// - the memory bus clock is half the platform clock.
// - the platform clock and the core complex bus clock are one clock.
// - a functional output pin is a configuration input during reset and drives only after it.
// - each configuration pin enables its weak pull-up only while in reset.
`timescale 1ns/1ps
`default_nettype none
`include "crsd_consts.svh"
module crsd_clock_ratio_strap_decoder (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic dev_reset_n,
    input wire crsd_pkg::crsd_straps_t strap_in,
    output logic [6:0] strap_pullup_en,
    output logic strap_shared_out,
    output logic strap_shared_oe,
    output crsd_pkg::crsd_ratio_t ratio_out,
    output logic ratio_locked,
    output logic platform_below_min,
    output logic mem_clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    import crsd_pkg::*;

    // ------------------------------------------------------------
    // synchronised pins
    // ------------------------------------------------------------
    crsd_straps_t straps_sync;
    logic dev_reset_n_sync;

    crsd_sync #(.WIDTH(8)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d({strap_in, dev_reset_n}),
        .q({straps_sync, dev_reset_n_sync})
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [7:0] mult_next;
    logic valid_next;
    logic [3:0] core_next;

    always_comb begin
        mult_next = 8'h00;
        valid_next = 1'b1;
        unique case (straps_sync.platform_ratio_strap)
            `CRSD_PR_16: mult_next = 8'h10;
            `CRSD_PR_2: mult_next = 8'h02;
            `CRSD_PR_3: mult_next = 8'h03;
            `CRSD_PR_4: mult_next = 8'h04;
            `CRSD_PR_5: mult_next = 8'h05;
            `CRSD_PR_6: mult_next = 8'h06;
            `CRSD_PR_8: mult_next = 8'h08;
            `CRSD_PR_9: mult_next = 8'h09;
            `CRSD_PR_10: mult_next = 8'h0a;
            `CRSD_PR_12: mult_next = 8'h0c;
            default: valid_next = 1'b0;
        endcase
    end

    always_comb begin
        unique case ({straps_sync.core_ratio_strap_upper,
                      straps_sync.core_ratio_strap_lower})
            2'b00: core_next = `CRSD_CR_HALF_00;
            2'b01: core_next = `CRSD_CR_HALF_01;
            2'b10: core_next = `CRSD_CR_HALF_10;
            2'b11: core_next = `CRSD_CR_HALF_11;
        endcase
    end

    // ------------------------------------------------------------
    // reset sequencing and capture
    // ------------------------------------------------------------
    crsd_state_t state_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= CRSD_HELD;
        end else if (!dev_reset_n_sync) begin
            state_reg <= CRSD_HELD;
        end else begin
            unique case (state_reg)
                CRSD_HELD: state_reg <= CRSD_CAPTURE;
                CRSD_CAPTURE: state_reg <= CRSD_RUN;
                CRSD_RUN: state_reg <= CRSD_RUN;
            endcase
        end
    end

    crsd_ratio_t ratio_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ratio_reg <= '0;
        end else if (state_reg == CRSD_CAPTURE) begin
            ratio_reg.plat_mult <= mult_next;
            ratio_reg.core_half <= core_next;
            ratio_reg.ratio_valid <= valid_next;
            ratio_reg.bus_64 <= ~straps_sync.bus_width_strap;
        end
    end

    // ------------------------------------------------------------
    // platform code capture
    // ------------------------------------------------------------
    logic [3:0] pcode_reg;
    logic stay_run;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pcode_reg <= 4'h0;
        end else if (state_reg == CRSD_CAPTURE) begin
            pcode_reg <= straps_sync.platform_ratio_strap;
        end
    end

    assign ratio_out = ratio_reg;
    assign ratio_locked = (state_reg == CRSD_RUN);
    assign stay_run = ratio_locked & dev_reset_n_sync;
    assign strap_pullup_en = (state_reg == CRSD_RUN) ? 7'h00 : 7'h7f;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] period_reg;
    logic [31:0] ref_hz_reg;
    logic wr_pend_reg;
    logic [11:0] addr_reg;

    wire logic take = hsel & hready & htrans[1];

    // ------------------------------------------------------------
    // write side: address phase noted, data lands a cycle later
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
        end else if (hready) begin
            wr_pend_reg <= take & hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_reg <= 12'h000;
        end else if (hready) begin
            addr_reg <= haddr[11:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= `CRSD_CTRL_RESET;
        end else if (wr_pend_reg && (addr_reg == `CRSD_ADDR_CTRL)) begin
            ctrl_reg <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_hz_reg <= `CRSD_REF_HZ_RESET;
        end else if (wr_pend_reg && (addr_reg == `CRSD_ADDR_REFHZ)) begin
            ref_hz_reg <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            period_reg <= 32'h0000_0000;
        end else if (wr_pend_reg && (addr_reg == `CRSD_ADDR_PERIOD)) begin
            period_reg <= hwdata;
        end
    end

    // ------------------------------------------------------------
    // derived frequencies: platform = ref * mult, core = plat * half / 2
    // ------------------------------------------------------------
    logic [39:0] plat_prod;
    logic [43:0] core_prod;
    logic [31:0] plat_hz;
    logic [31:0] core_hz;
    logic [31:0] mem_hz;

    assign plat_prod = ref_hz_reg * ratio_reg.plat_mult;
    assign plat_hz = plat_prod[31:0];
    assign core_prod = plat_hz * ratio_reg.core_half;
    assign core_hz = core_prod[32:1];
    assign mem_hz = {1'b0, plat_hz[31:1]};
    assign platform_below_min = ratio_locked & (plat_hz < `CRSD_PLAT_MIN_HZ);

    // ------------------------------------------------------------
    // status word
    // ------------------------------------------------------------
    logic [31:0] status;

    always_comb begin
        status = 32'h0000_0000;
        status[`CRSD_ST_PRATIO_LSB +: 4] = pcode_reg;
        status[`CRSD_ST_MULT_LSB +: 8] = ratio_reg.plat_mult;
        status[`CRSD_ST_CRATIO_LSB +: 2] = ratio_reg.core_half[1:0] - 2'b00;
        status[`CRSD_ST_VALID_BIT] = ratio_reg.ratio_valid;
        status[`CRSD_ST_BUS64_BIT] = ratio_reg.bus_64;
        status[`CRSD_ST_LOCKED_BIT] = ratio_locked;
        status[`CRSD_ST_SLOW_BIT] = platform_below_min;
    end

    // ------------------------------------------------------------
    // read side: data registered at the address phase
    // ------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        unique case (haddr[11:0])
            `CRSD_ADDR_STATUS: rd_mux = status;
            `CRSD_ADDR_CTRL: rd_mux = ctrl_reg;
            `CRSD_ADDR_PERIOD: rd_mux = period_reg;
            `CRSD_ADDR_REFHZ: rd_mux = ref_hz_reg;
            `CRSD_ADDR_PLATHZ: rd_mux = plat_hz;
            `CRSD_ADDR_COREHZ: rd_mux = core_hz;
            `CRSD_ADDR_MEMHZ: rd_mux = mem_hz;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take & ~hwrite) begin
            hrdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // bus response: no wait states, always okay
    // ------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ------------------------------------------------------------
    // shared strap pin: input in reset, output afterwards
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_shared_oe <= 1'b0;
        end else begin
            strap_shared_oe <= stay_run & ctrl_reg[`CRSD_CTRL_OUT_EN_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_shared_out <= 1'b0;
        end else begin
            strap_shared_out <= ctrl_reg[`CRSD_CTRL_OUT_VAL_BIT];
        end
    end

    // ------------------------------------------------------------
    // memory bus enable: one hclk pulse every second platform tick
    // ------------------------------------------------------------
    logic [7:0] mem_cnt_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_cnt_reg <= 8'h00;
        end else if (!stay_run) begin
            mem_cnt_reg <= 8'h00;
        end else if (mem_cnt_reg == `CRSD_MEM_DIV - 8'h01) begin
            mem_cnt_reg <= 8'h00;
        end else begin
            mem_cnt_reg <= mem_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_clk_en <= 1'b0;
        end else begin
            mem_clk_en <= stay_run && (mem_cnt_reg == `CRSD_MEM_DIV - 8'h01);
        end
    end
endmodule
`default_nettype wire

// ==== dv/crsd_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// strap decoder port checker
// ----------------------------------------
module crsd_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic dev_reset_n,
    input wire logic [6:0] strap_pullup_en,
    input wire logic strap_shared_oe,
    input wire crsd_pkg::crsd_ratio_t ratio_out,
    input wire logic ratio_locked,
    input wire logic platform_below_min,
    input wire logic mem_clk_en
);
    import crsd_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    pull_window_a: assert property (strap_pullup_en == {7{!ratio_locked}})
        else $error("pull-up enable does not follow reset state");
    pin_release_a: assert property (!ratio_locked |-> !strap_shared_oe)
        else $error("shared pin driven outside run state");
    held_reset_a: assert property (!dev_reset_n [*5] |-> !ratio_locked)
        else $error("lock seen while device reset held");
    lock_delay_a: assert property ($rose(dev_reset_n) |-> ##[2:8] ratio_locked)
        else $error("no lock after device reset release");
    ratio_hold_a: assert property (ratio_locked && $past(ratio_locked) |-> $stable(ratio_out))
        else $error("ratio changed while locked");
    mult_code_a: assert property (ratio_locked |-> ratio_out.ratio_valid ==
        (ratio_out.plat_mult inside {8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0a,
        8'h0c, 8'h10})) else $error("valid flag does not match multiplier");
    reserved_zero_a: assert property (ratio_locked && !ratio_out.ratio_valid |->
        ratio_out.plat_mult == 8'h00) else $error("reserved code gave a multiplier");
    core_range_a: assert property (ratio_locked |-> ratio_out.core_half inside {[4'h4:4'h7]})
        else $error("core ratio outside 2 to 3.5");
    mem_single_a: assert property (mem_clk_en |-> ratio_locked ##1 !mem_clk_en)
        else $error("memory enable not a single locked pulse");
    mem_every_a: assert property (ratio_locked && $past(ratio_locked) && $past(ratio_locked, 2)
        && !mem_clk_en |-> $past(mem_clk_en)) else $error("memory enable missed a cycle");
    slow_locked_a: assert property (platform_below_min |-> ratio_locked)
        else $error("below-minimum flag while unlocked");
    lock_c: cover property ($rose(ratio_locked));
    reserved_c: cover property (ratio_locked && !ratio_out.ratio_valid);
    drive_c: cover property (strap_shared_oe);
endmodule
bind crsd_clock_ratio_strap_decoder crsd_props u_props (
    .hclk(hclk),
    .hresetn(hresetn),
    .dev_reset_n(dev_reset_n),
    .strap_pullup_en(strap_pullup_en),
    .strap_shared_oe(strap_shared_oe),
    .ratio_out(ratio_out),
    .ratio_locked(ratio_locked),
    .platform_below_min(platform_below_min),
    .mem_clk_en(mem_clk_en)
);
`default_nettype wire

// ==== dv/crsd_board.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// board reset logic and strap drivers
// ----------------------------------------
module crsd_board import crsd_pkg::*; (
    input wire logic hclk,
    input wire logic rst_req_n,
    input wire crsd_straps_t cfg,
    output logic dev_reset_n = 1'b0,
    output crsd_straps_t strap_in
);
    logic [2:0] hold_cnt = 3'h7;
    logic [6:0] junk = 7'h55;
    always @(posedge hclk) begin
        dev_reset_n <= rst_req_n;
        junk <= ~junk;
        if (!dev_reset_n)
            hold_cnt <= 3'h7;
        else if (hold_cnt != 3'h0)
            hold_cnt <= hold_cnt - 3'h1;
    end
    // every strap driven through reset, then released to floating levels except the bus-width strap, which is held at 1
    assign strap_in = (hold_cnt != 3'h0) ? cfg : {junk[6:1], 1'b1};
endmodule
`default_nettype wire

// ==== dv/tb_clock_ratio_strap_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// strap decoder testbench
// ----------------------------------------
module tb_clock_ratio_strap_decoder;
    import crsd_pkg::*;
    logic hclk = 0, hresetn = 0, rst_req_n = 0, hwrite = 0, rd_phase = 0, locked_d = 0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    crsd_straps_t cfg = '0, strap_in;
    crsd_ratio_t ratio_out;
    logic [6:0] pull;
    logic dev_reset_n, oe, sout, locked, below_min, hreadyout, hresp;
    logic [31:0] expq[$];
    int err_total = 0, checked = 0;
    initial forever #2.5 hclk = ~hclk;
    crsd_board board (.hclk(hclk), .rst_req_n(rst_req_n), .cfg(cfg), .dev_reset_n(dev_reset_n),
        .strap_in(strap_in));
    crsd_clock_ratio_strap_decoder dut (
        .hclk(hclk), .hresetn(hresetn), .dev_reset_n(dev_reset_n), .strap_in(strap_in),
        .strap_pullup_en(pull), .strap_shared_out(sout), .strap_shared_oe(oe),
        .ratio_out(ratio_out), .ratio_locked(locked), .platform_below_min(below_min),
        .mem_clk_en(), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        rd_phase <= !wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_phase <= 1'b0;
        chk({31'h0, hresp}, 32'h0);
    endtask
    function automatic crsd_ratio_t exp_ratio(input crsd_straps_t s);
        crsd_ratio_t r;
        case (s.platform_ratio_strap)
            4'h0: r.plat_mult = 8'h10;
            4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hc: r.plat_mult = {4'h0, s[6:3]};
            default: r.plat_mult = 8'h00;
        endcase
        r.core_half = 4'h4 + {2'b00, s.core_ratio_strap_upper, s.core_ratio_strap_lower};
        r.ratio_valid = r.plat_mult != 8'h00;
        r.bus_64 = !s.bus_width_strap;
        return r;
    endfunction
    // results come back in request order: lock events and read data phases
    always @(posedge hclk) begin
        locked_d <= locked;
        if ((rd_phase && hreadyout) || (locked === 1'b1 && !locked_d))
            chk(rd_phase ? hrdata : {18'h0, ratio_out}, expq.size() ? expq.pop_front() : 'x);
    end
    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        print_verdict;
    end
    initial begin
        logic [63:0] prod;
        logic [31:0] rnd, ref_hz;
        logic ex_slow;
        crsd_ratio_t er;
        void'($urandom(95928));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        expq.push_back(32'h03f9_40aa);
        ahb(1'b0, 32'h0c, 32'h0);
        expq.push_back(32'h0);
        ahb(1'b0, 32'h40, 32'h0);
        for (int i = 0; i < 16; i++) begin
            rnd = $urandom;
            cfg <= {i[3:0], rnd[2:0]};
            er = exp_ratio({i[3:0], rnd[2:0]});
            rst_req_n <= 1'b0;
            repeat (6) @(posedge hclk);
            expq.push_back({18'h0, er});
            rst_req_n <= 1'b1;
            for (int k = 0; k < 20 && locked !== 1'b1; k++) @(posedge hclk);
            repeat (8) @(posedge hclk);
            ref_hz = $urandom_range(200000000, 1);
            ahb(1'b1, 32'h0c, ref_hz);
            prod = 64'(ref_hz) * 64'(er.plat_mult);
            ex_slow = prod < 64'd200000000;
            expq.push_back({14'h0, ex_slow, 1'b1, er.bus_64, er.ratio_valid, er.core_half[1:0],
                er.plat_mult, i[3:0]});
            ahb(1'b0, 32'h00, 32'h0);
            chk({31'h0, below_min}, {31'h0, ex_slow});
            ahb(1'b1, 32'h10, 32'hffff_ffff);
            expq.push_back(prod[31:0]);
            ahb(1'b0, 32'h10, 32'h0);
            expq.push_back({1'b0, prod[31:1]});
            ahb(1'b0, 32'h18, 32'h0);
            prod = (64'(prod[31:0]) * 64'(er.core_half)) >> 1;
            expq.push_back(prod[31:0]);
            ahb(1'b0, 32'h14, 32'h0);
        end
        ahb(1'b1, 32'h04, 32'h3);
        expq.push_back(32'h3);
        ahb(1'b0, 32'h04, 32'h0);
        chk({30'h0, oe, sout}, 32'h3);
        rst_req_n <= 1'b0;
        repeat (6) @(posedge hclk);
        chk({30'h0, oe, pull == 7'h7f}, 32'h1);
        expq.push_back({18'h0, er});
        rst_req_n <= 1'b1;
        for (int k = 0; k < 20 && locked !== 1'b1; k++) @(posedge hclk);
        repeat (4) @(posedge hclk);
        chk(32'(expq.size()), 32'h0);
        print_verdict;
    end
endmodule
`default_nettype wire
